/* File: clkc_top.sv */
`timescale 1ns/10ps
`include "clkc_params.svh"
module clkc_top #(
  parameter int CNT_WIDTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Peripheral bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Slow system RC clock level
  input wire logic slow_system_rc,
  // Fast RC oscillator
  input wire logic fast_rc_on,
  input wire logic fast_rc_tune_done,
  input wire logic [15:0] fast_rc_count,
  input wire logic [15:0] fast_rc_target,
  input wire logic [15:0] tuning_window,
  // Synth and sleep
  input wire logic synth_fault,
  input wire logic sleep_exit,
  // Frequency-locked loop
  input wire logic fll_ref_stopped_in,
  input wire logic fll_sync_ready_in,
  input wire logic fll_fine_locked_in,
  input wire logic fll_coarse_locked_in,
  // Crystal oscillator control
  output logic crystal_osc_on,
  output logic [3:0] crystal_startup,
  output logic [1:0] crystal_gain,
  output logic auto_gain_test,
  output logic crystal_mode,
  output logic osc_output_pin_free,
  // Synth control
  output logic synth_on,
  output logic [5:0] synth_settle_cycles,
  output logic [3:0] synth_multiplier,
  output logic [3:0] synth_divider,
  output logic [2:0] synth_options,
  output logic [1:0] synth_ref_select,
  output logic [4:0] synth_ratio_num,
  output logic [3:0] synth_ratio_den,
  // Pending interrupt bits
  output logic [31:0] irq_pending_reg
);
  clkc_pkg::clkc_word_type osc_q;
  clkc_pkg::clkc_word_type synth_q;
  clkc_pkg::clkc_word_type pending_q;
  clkc_pkg::clkc_word_type status;
  clkc_pkg::clkc_word_type status_prev_q;
  clkc_pkg::clkc_word_type events;
  clkc_pkg::clkc_word_type clear_mask;
  clkc_pkg::clkc_word_type rdata_q;
  clkc_pkg::clkc_release_type rel_q;
  logic [9:0] rel_addr_q;
  logic access;
  logic wr;
  logic mapped;
  logic protected_hit;
  logic released;
  logic osc_write;
  logic synth_write;
  logic synth_fields_write;
  logic violation;
  logic slow_q;
  logic slow_tick;
  logic [15:0] diff;
  logic frc_lock;
  logic frc_lock_q;
  logic frc_on_q;
  logic frc_drop_q;
  logic syn_restart;
  logic syn_done;
  logic syn_lock;
  logic syn_lock_q;
  logic syn_drop_q;
  logic xosc_done;
  logic xosc_rdy;
  logic [CNT_WIDTH-1:0] xosc_target;
  logic [CNT_WIDTH-1:0] syn_target;
  logic [4:0] mul_plus;

  // Bus decode
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign pready = 1'b1;
  always_comb begin
    case (paddr)
      `CLKC_OFF_PENDING,
      `CLKC_OFF_CLEAR,
      `CLKC_OFF_STATUS,
      `CLKC_OFF_RELEASE,
      `CLKC_OFF_OSC,
      `CLKC_OFF_SYNTH: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = access && !mapped;

  // Release sequence
  assign protected_hit = (paddr == `CLKC_OFF_OSC) || (paddr == `CLKC_OFF_SYNTH);
  assign released = (rel_q == clkc_pkg::CLKC_REL_ARMED) && (rel_addr_q == paddr);
  assign osc_write = wr && (paddr == `CLKC_OFF_OSC) && released;
  assign synth_write = wr && (paddr == `CLKC_OFF_SYNTH) && released;
  assign violation = wr && protected_hit && !released;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rel_q <= clkc_pkg::CLKC_REL_IDLE;
      rel_addr_q <= 10'h000;
    end else if (access) begin
      // Any access other than a valid key write spends an armed release
      if (pwrite && paddr == `CLKC_OFF_RELEASE &&
          pwdata[`CLKC_KEY_MSB:`CLKC_KEY_LSB] == `CLKC_KEY_VALUE) begin
        rel_q <= clkc_pkg::CLKC_REL_ARMED;
        rel_addr_q <= pwdata[`CLKC_RADDR_MSB:0];
      end else begin
        case (rel_q)
          clkc_pkg::CLKC_REL_ARMED: rel_q <= clkc_pkg::CLKC_REL_IDLE;
          clkc_pkg::CLKC_REL_IDLE: rel_q <= clkc_pkg::CLKC_REL_IDLE;
          default: rel_q <= clkc_pkg::CLKC_REL_IDLE;
        endcase
      end
    end
  end

  // Crystal oscillator control
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      osc_q <= `CLKC_RESET_VALUE;
    end else if (osc_write) begin
      osc_q <= pwdata & 32'h0001_0F0F;
    end
  end

  assign crystal_osc_on = osc_q[`CLKC_OSC_ON_BIT];
  assign crystal_startup = osc_q[`CLKC_OSC_START_MSB:`CLKC_OSC_START_LSB];
  assign crystal_gain = osc_q[`CLKC_OSC_GAIN_MSB:`CLKC_OSC_GAIN_LSB];
  assign auto_gain_test = osc_q[`CLKC_OSC_AGC_BIT];
  assign crystal_mode = osc_q[`CLKC_OSC_MODE_BIT];
  assign osc_output_pin_free = !osc_q[`CLKC_OSC_MODE_BIT];

  // Slow RC edge, the time base of all settle counts
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      slow_q <= 1'b0;
    end else begin
      slow_q <= slow_system_rc;
    end
  end
  assign slow_tick = slow_system_rc && !slow_q;

  // Start-up delay of 2^field slow RC cycles
  assign xosc_target = CNT_WIDTH'(1) << crystal_startup;
  clkc_settle_counter #(
    .WIDTH(CNT_WIDTH)
  ) u_xosc_settle (
    .ref_clk(ref_clk),
    .reset(reset),
    .restart(!crystal_osc_on || osc_write),
    .tick(slow_tick),
    .target(xosc_target),
    .done(xosc_done)
  );
  assign xosc_rdy = crystal_osc_on && xosc_done;

  // Synth control; only a clear of the enable passes while it is on
  assign synth_fields_write = synth_write && !synth_q[`CLKC_SYN_ON_BIT];
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      synth_q <= `CLKC_RESET_VALUE;
    end else if (synth_fields_write) begin
      synth_q <= pwdata & 32'h3F0F_0F3F;
    end else if (synth_write && !pwdata[`CLKC_SYN_ON_BIT]) begin
      synth_q[`CLKC_SYN_ON_BIT] <= 1'b0;
    end
  end

  assign synth_on = synth_q[`CLKC_SYN_ON_BIT];
  assign synth_settle_cycles = synth_q[`CLKC_SYN_CNT_MSB:`CLKC_SYN_CNT_LSB];
  assign synth_multiplier = synth_q[`CLKC_SYN_MUL_MSB:`CLKC_SYN_MUL_LSB];
  assign synth_divider = synth_q[`CLKC_SYN_DIV_MSB:`CLKC_SYN_DIV_LSB];
  assign synth_options = synth_q[`CLKC_SYN_OPT_MSB:`CLKC_SYN_OPT_LSB];
  assign synth_ref_select = synth_q[`CLKC_SYN_REF_MSB:`CLKC_SYN_REF_LSB];

  // Frequency ratio as numerator over denominator
  assign mul_plus = {1'b0, synth_multiplier} + 5'h01;
  always_comb begin
    if (synth_divider == 4'h0) begin
      synth_ratio_num = {mul_plus[3:0], 1'b0};
      synth_ratio_den = 4'h1;
    end else begin
      synth_ratio_num = mul_plus;
      synth_ratio_den = synth_divider;
    end
  end

  // Settle count after a write or a wake from sleep
  assign syn_restart = synth_fields_write || sleep_exit || !synth_on;
  assign syn_target = CNT_WIDTH'(synth_settle_cycles);
  clkc_settle_counter #(
    .WIDTH(CNT_WIDTH)
  ) u_synth_settle (
    .ref_clk(ref_clk),
    .reset(reset),
    .restart(syn_restart),
    .tick(slow_tick),
    .target(syn_target),
    .done(syn_done)
  );
  // Fault only masks lock; lock returns once the fault clears
  assign syn_lock = synth_on && syn_done && !synth_fault;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      syn_lock_q <= 1'b0;
      syn_drop_q <= 1'b0;
    end else begin
      syn_lock_q <= syn_lock;
      if (syn_lock_q && !syn_lock) begin
        syn_drop_q <= 1'b1;
      end else if (synth_fields_write && pwdata[`CLKC_SYN_ON_BIT]) begin
        syn_drop_q <= 1'b0;
      end
    end
  end

  // Fast RC lock within the tuning window
  assign diff = (fast_rc_count >= fast_rc_target) ? (fast_rc_count - fast_rc_target)
                                                  : (fast_rc_target - fast_rc_count);
  assign frc_lock = fast_rc_on && fast_rc_tune_done && (diff <= tuning_window);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      frc_lock_q <= 1'b0;
      frc_on_q <= 1'b0;
      frc_drop_q <= 1'b0;
    end else begin
      frc_lock_q <= frc_lock;
      frc_on_q <= fast_rc_on;
      if (frc_lock_q && !frc_lock) begin
        frc_drop_q <= 1'b1;
      end else if (fast_rc_on && !frc_on_q) begin
        frc_drop_q <= 1'b0;
      end
    end
  end

  // Status word
  always_comb begin
    status = '0;
    status[`CLKC_BIT_FRC_DROP] = frc_drop_q;
    status[`CLKC_BIT_FRC_LOCK] = frc_lock;
    status[`CLKC_BIT_SYN_DROP] = syn_drop_q;
    status[`CLKC_BIT_SYN_LOCK] = syn_lock;
    status[`CLKC_BIT_FLL_RCS] = fll_ref_stopped_in;
    status[`CLKC_BIT_FLL_RDY] = fll_sync_ready_in;
    status[`CLKC_BIT_FLL_FINE] = fll_fine_locked_in;
    status[`CLKC_BIT_FLL_COARSE] = fll_coarse_locked_in;
    status[`CLKC_BIT_XOSC_RDY] = xosc_rdy;
  end

  // Pending bits: rising status edges and release violations
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_prev_q <= `CLKC_RESET_VALUE;
    end else begin
      status_prev_q <= status;
    end
  end

  always_comb begin
    events = status & ~status_prev_q;
    events[`CLKC_BIT_ACCESS_ERR] = violation;
  end

  assign clear_mask = (wr && paddr == `CLKC_OFF_CLEAR) ? (pwdata & `CLKC_IRQ_DEFINED) : '0;

  // Set beats clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pending_q <= `CLKC_RESET_VALUE;
    end else begin
      pending_q <= (pending_q & ~clear_mask) | events;
    end
  end
  assign irq_pending_reg = pending_q;

  // Read data registered in the setup phase
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_q <= `CLKC_RESET_VALUE;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `CLKC_OFF_PENDING: rdata_q <= pending_q;
        `CLKC_OFF_STATUS: rdata_q <= status;
        `CLKC_OFF_OSC: rdata_q <= osc_q;
        `CLKC_OFF_SYNTH: rdata_q <= synth_q;
        default: rdata_q <= '0;
      endcase
    end
  end
  assign prdata = rdata_q;
endmodule

/* File: clkc_params.svh */
// What this block does
// - Writing one to an interrupt clear bit clears that pending status bit.
// - Fast RC lock-dropped flag sets on lock loss, else reads zero.
// - Fast RC locked means tuning done and count within tuning window.
// - Synth lock-dropped sets on lock loss, by disable, fault or sleep exit.
// - Synth locked reads one only when the output is accurate.
// - FLL reference-stopped flag mirrors the loop's stopped-reference condition.
// - FLL sync-ready reads one only while loop register access is valid.
// - FLL fine-locked flag reads one once fine lock is reached.
// - FLL coarse-locked flag reads one once coarse lock is reached.
// - Crystal ready reads one only when enabled and start-up has elapsed.
// - Release register holds key in top byte, ten-bit offset below.
// - Crystal enable bit starts the oscillator at one, stops it at zero.
// - Start-up field sets ready delay; gain field sets drive gain.
// - Mode zero: external clock, output pin free; one: crystal on both.
// - After synth write or sleep exit, count slow RC cycles before lock.
// - Ratio is (mul+1)/div, or 2*(mul+1) over 1 when divider is zero, the numerator wrapping to 0 when mul is 15.
// - Pending bits set on their event and hold until cleared.
// - Writes to synth control are discarded while the synth is on, except a clear of the enable bit.
`ifndef CLKC_PARAMS_SVH
`define CLKC_PARAMS_SVH
`define CLKC_OFF_PENDING 10'h00C
`define CLKC_OFF_CLEAR 10'h010
`define CLKC_OFF_STATUS 10'h014
`define CLKC_OFF_RELEASE 10'h018
`define CLKC_OFF_OSC 10'h01C
`define CLKC_OFF_SYNTH 10'h020
`define CLKC_RESET_VALUE 32'h0000_0000
`define CLKC_IRQ_DEFINED 32'h8000_60DF
`define CLKC_BIT_ACCESS_ERR 31
`define CLKC_BIT_FRC_DROP 14
`define CLKC_BIT_FRC_LOCK 13
`define CLKC_BIT_SYN_DROP 7
`define CLKC_BIT_SYN_LOCK 6
`define CLKC_BIT_FLL_RCS 4
`define CLKC_BIT_FLL_RDY 3
`define CLKC_BIT_FLL_FINE 2
`define CLKC_BIT_FLL_COARSE 1
`define CLKC_BIT_XOSC_RDY 0
`define CLKC_KEY_VALUE 8'hAA
`define CLKC_KEY_MSB 31
`define CLKC_KEY_LSB 24
`define CLKC_RADDR_MSB 9
`define CLKC_OSC_ON_BIT 16
`define CLKC_OSC_START_MSB 11
`define CLKC_OSC_START_LSB 8
`define CLKC_OSC_AGC_BIT 3
`define CLKC_OSC_GAIN_MSB 2
`define CLKC_OSC_GAIN_LSB 1
`define CLKC_OSC_MODE_BIT 0
`define CLKC_SYN_CNT_MSB 29
`define CLKC_SYN_CNT_LSB 24
`define CLKC_SYN_MUL_MSB 19
`define CLKC_SYN_MUL_LSB 16
`define CLKC_SYN_DIV_MSB 11
`define CLKC_SYN_DIV_LSB 8
`define CLKC_SYN_OPT_MSB 5
`define CLKC_SYN_OPT_LSB 3
`define CLKC_SYN_REF_MSB 2
`define CLKC_SYN_REF_LSB 1
`define CLKC_SYN_ON_BIT 0
`endif

/* File: clkc_pkg.sv */
package clkc_pkg;
  typedef logic [31:0] clkc_word_type;
  typedef enum logic [1:0] {
    CLKC_REL_IDLE = 2'b01,
    CLKC_REL_ARMED = 2'b10
  } clkc_release_type;
endpackage

/* File: clkc_settle_counter.sv */
`timescale 1ns/10ps
module clkc_settle_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Control
  input wire logic restart,
  input wire logic tick,
  input wire logic [WIDTH-1:0] target,
  // Result
  output logic done
);
  logic [WIDTH-1:0] count_q;
  logic done_q;

  always_ff @(posedge ref_clk) begin
    if (reset || restart) begin
      count_q <= '0;
      done_q <= 1'b0;
    end else if (count_q >= target) begin
      done_q <= 1'b1;
    end else if (tick) begin
      count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign done = done_q;
endmodule

/* File: clkc_top_chk_sva.sv */
`timescale 1ns/10ps
module clkc_top_chk (
  // Clock and bus
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // Control outputs
  input wire logic crystal_osc_on,
  input wire logic [3:0] crystal_startup,
  input wire logic [1:0] crystal_gain,
  input wire logic auto_gain_test,
  input wire logic crystal_mode,
  input wire logic osc_output_pin_free,
  input wire logic synth_on,
  input wire logic [3:0] synth_multiplier,
  input wire logic [3:0] synth_divider,
  input wire logic [4:0] synth_ratio_num,
  input wire logic [3:0] synth_ratio_den,
  input wire logic [31:0] irq_pending_reg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic acc;
  logic clr;
  logic osc_acc;
  logic [8:0] osc_f;
  assign acc = psel && penable && pwrite;
  assign osc_acc = acc && paddr == 10'h01C;
  assign clr = acc && paddr == 10'h010;
  assign osc_f = {crystal_osc_on, crystal_startup, crystal_gain, auto_gain_test, crystal_mode};
  sequence bad_key_s;
    acc && paddr == 10'h018 && pwdata[31:24] != 8'hAA;
  endsequence
  sequence osc_wr_s;
    acc && paddr == 10'h01C;
  endsequence
  chk_pin_free: assert property (osc_output_pin_free == !crystal_mode)
    else $error("pin free flag wrong");
  chk_ratio_double: assert property (synth_divider == 4'h0 |->
    synth_ratio_num == 5'((5'(synth_multiplier) + 5'h01) << 1) && synth_ratio_den == 4'h1)
    else $error("ratio with zero divider wrong");
  chk_ratio_plain: assert property (synth_divider != 4'h0 |->
    synth_ratio_num == 5'(synth_multiplier) + 5'h01 && synth_ratio_den == synth_divider)
    else $error("ratio wrong");
  chk_clear_zero: assert property (clr |=>
    ($past(irq_pending_reg) & ~$past(pwdata) & ~irq_pending_reg) == 32'h0)
    else $error("zero clear bit dropped a pending bit");
  chk_pending_hold: assert property (!clr |=>
    ($past(irq_pending_reg) & ~irq_pending_reg) == 32'h0)
    else $error("pending bit fell without clear");
  chk_synth_frozen: assert property (synth_on |=> $stable(synth_multiplier) && $stable(synth_divider))
    else $error("synth fields moved while on");
  chk_osc_guard: assert property ($changed(osc_f) |-> $past(osc_acc))
    else $error("osc fields moved without a write");
  chk_bad_key: assert property (bad_key_s ##2 osc_wr_s |=> $stable(osc_f))
    else $error("wrong key released a write");
  chk_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access");
endmodule

/* File: clkc_top_tb_top.sv */
`timescale 1ns/10ps
module clkc_top_tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata, irq_pending_reg, seed = 32'hB884, rd, w;
  logic slow_system_rc = 1'b0, fast_rc_on = 1'b0, fast_rc_tune_done = 1'b0;
  logic [15:0] fast_rc_count = 16'h0, fast_rc_target = 16'h0, tuning_window = 16'h0;
  logic synth_fault = 1'b0, sleep_exit = 1'b0, pready, pslverr, lk, nl, dr;
  logic [3:0] fll_in = 4'h0, crystal_startup, synth_multiplier, synth_divider, synth_ratio_den;
  logic crystal_osc_on, auto_gain_test, crystal_mode, osc_output_pin_free, synth_on;
  logic [1:0] crystal_gain, synth_ref_select;
  logic [5:0] synth_settle_cycles;
  logic [2:0] synth_options;
  logic [4:0] synth_ratio_num;
  int bad_count = 0, n_checks = 0, d, mul, div;
  always #25 ref_clk = ~ref_clk;
  // Slow tick every 8 cycles, phase unrelated to bus traffic
  always begin
    repeat (4) @(negedge ref_clk);
    slow_system_rc = ~slow_system_rc;
  end
  clkc_top clkc_top_i (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_system_rc(slow_system_rc), .fast_rc_on(fast_rc_on), .fast_rc_tune_done(fast_rc_tune_done),
    .fast_rc_count(fast_rc_count), .fast_rc_target(fast_rc_target), .tuning_window(tuning_window),
    .synth_fault(synth_fault), .sleep_exit(sleep_exit), .fll_ref_stopped_in(fll_in[3]),
    .fll_sync_ready_in(fll_in[2]), .fll_fine_locked_in(fll_in[1]), .fll_coarse_locked_in(fll_in[0]),
    .crystal_osc_on(crystal_osc_on), .crystal_startup(crystal_startup), .crystal_gain(crystal_gain),
    .auto_gain_test(auto_gain_test), .crystal_mode(crystal_mode), .osc_output_pin_free(osc_output_pin_free),
    .synth_on(synth_on), .synth_settle_cycles(synth_settle_cycles), .synth_multiplier(synth_multiplier),
    .synth_divider(synth_divider), .synth_options(synth_options), .synth_ref_select(synth_ref_select),
    .synth_ratio_num(synth_ratio_num), .synth_ratio_den(synth_ratio_den), .irq_pending_reg(irq_pending_reg));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] syn_out();
    return {2'h0, synth_settle_cycles, 4'h0, synth_multiplier, 4'h0, synth_divider, 2'h0, synth_options,
      synth_ref_select, synth_on};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Entered and left at a falling edge, so two calls run back to back
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] dat, input logic err);
    psel = 1'b1;
    penable = 1'b0;
    pwrite = wr;
    paddr = a;
    pwdata = dat;
    @(negedge ref_clk);
    penable = 1'b1;
    @(posedge ref_clk);
    rd = prdata;
    check({30'h0, pready, pslverr}, {30'h0, 1'b1, err});
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge ref_clk);
  endtask
  // Pending bits land a cycle after their event
  task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
    repeat (2) @(negedge ref_clk);
    bus(1'b0, a, 32'h0, 1'b0);
    check(rd, exp);
  endtask
  task automatic unlock_wr(input logic [9:0] a, input logic [31:0] dat);
    bus(1'b1, 10'h018, {8'hAA, 14'h0, a}, 1'b0);
    bus(1'b1, a, dat, 1'b0);
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #300000;
    bad_count++;
    wrap_up;
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    rd_chk(10'h014, 32'h0);
    check({22'h0, osc_output_pin_free, synth_ratio_num, synth_ratio_den}, {22'h0, 1'b1, 5'h02, 4'h1});
    rd_chk(10'h00C, 32'h0);
    bus(1'b0, 10'h3FC, 32'h0, 1'b1);
    bus(1'b1, 10'h01C, 32'h0001_0000, 1'b0);
    rd_chk(10'h00C, 32'h8000_0000);
    bus(1'b1, 10'h010, 32'h7FFF_FFFF, 1'b0);
    rd_chk(10'h00C, 32'h8000_0000);
    bus(1'b1, 10'h010, 32'h8000_0000, 1'b0);
    rd_chk(10'h00C, 32'h0);
    bus(1'b1, 10'h018, 32'h5500_001C, 1'b0);
    bus(1'b1, 10'h01C, 32'h0001_0000, 1'b0);
    bus(1'b1, 10'h018, 32'hAA00_001C, 1'b0);
    bus(1'b0, 10'h014, 32'h0, 1'b0);
    bus(1'b1, 10'h01C, 32'h0001_0000, 1'b0);
    rd_chk(10'h01C, 32'h0);
    bus(1'b1, 10'h010, 32'hFFFF_FFFF, 1'b0);
    for (int i = 0; i < 4; i++) begin
      w = (rnd() & 32'h0000_030F) | 32'h0001_0000;
      unlock_wr(10'h01C, w);
      check(32'({crystal_osc_on, crystal_startup, crystal_gain, auto_gain_test, crystal_mode, osc_output_pin_free}),
        32'({w[16], w[11:8], w[2:1], w[3], w[0], !w[0]}));
      rd_chk(10'h01C, w);
      repeat (90) @(negedge ref_clk);
      rd_chk(10'h014, 32'h1);
    end
    rd_chk(10'h00C, 32'h1);
    bus(1'b1, 10'h010, 32'h1, 1'b0);
    rd_chk(10'h00C, 32'h0);
    unlock_wr(10'h01C, 32'h0);
    rd_chk(10'h014, 32'h0);
    for (int i = 0; i < 8; i++) begin
      w = rnd();
      fll_in = w[3:0];
      rd_chk(10'h014, {27'h0, fll_in, 1'b0});
    end
    fll_in = 4'h0;
    fast_rc_on = 1'b1;
    lk = 1'b0;
    dr = 1'b0;
    for (int i = 0; i < 12; i++) begin
      w = rnd();
      d = int'(w[20:16]) - 16;
      fast_rc_target = {1'b0, w[14:0]} + 16'h0100;
      fast_rc_count = 16'(int'(fast_rc_target) + d);
      tuning_window = {12'h0, w[27:24]};
      fast_rc_tune_done = w[31] | w[30];
      nl = fast_rc_tune_done && (d < 0 ? -d : d) <= int'(tuning_window);
      dr = dr | (lk & !nl);
      lk = nl;
      rd_chk(10'h014, {17'h0, dr, lk, 13'h0});
    end
    fast_rc_on = 1'b0;
    @(negedge ref_clk);
    fast_rc_on = 1'b1;
    fast_rc_tune_done = 1'b0;
    bus(1'b1, 10'h010, 32'hFFFF_FFFF, 1'b0);
    w = rnd();
    mul = 2 + int'(w[11:8]) % 14;
    div = int'(w[3:0]);
    w = (w & 32'h0700_003E) | 32'(mul << 16) | 32'(div << 8) | 32'h1;
    unlock_wr(10'h020, w);
    check(syn_out(), w);
    check({27'h0, synth_ratio_num}, div == 0 ? 32'((2 * (mul + 1)) % 32) : 32'(mul + 1));
    check({28'h0, synth_ratio_den}, div == 0 ? 32'h1 : 32'(div));
    repeat (90) @(negedge ref_clk);
    rd_chk(10'h014, 32'h40);
    rd_chk(10'h00C, 32'h40);
    check(irq_pending_reg, 32'h40);
    synth_fault = 1'b1;
    rd_chk(10'h014, 32'h80);
    synth_fault = 1'b0;
    rd_chk(10'h014, 32'hC0);
    unlock_wr(10'h020, w ^ 32'h000F_0F00);
    check(syn_out(), w);
    unlock_wr(10'h020, 32'h0);
    check(syn_out(), w & 32'hFFFF_FFFE);
    rd_chk(10'h014, 32'h80);
    // Sleep exit midway must push the lock out past the first count
    w = (w & 32'hC0FF_FFFF) | 32'h0800_0001;
    unlock_wr(10'h020, w);
    repeat (50) @(negedge ref_clk);
    sleep_exit = 1'b1;
    @(negedge ref_clk);
    sleep_exit = 1'b0;
    repeat (18) @(negedge ref_clk);
    rd_chk(10'h014, 32'h0);
    repeat (60) @(negedge ref_clk);
    rd_chk(10'h014, 32'h40);
    wrap_up;
  end
endmodule
bind clkc_top clkc_top_chk clkc_top_chk_i (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .crystal_osc_on(crystal_osc_on),
  .crystal_startup(crystal_startup), .crystal_gain(crystal_gain), .auto_gain_test(auto_gain_test),
  .crystal_mode(crystal_mode), .osc_output_pin_free(osc_output_pin_free), .synth_on(synth_on),
  .synth_multiplier(synth_multiplier), .synth_divider(synth_divider), .synth_ratio_num(synth_ratio_num),
  .synth_ratio_den(synth_ratio_den), .irq_pending_reg(irq_pending_reg));
